// >>> rtl/srcp_params.svh
// constants of the serial register control port
`ifndef SRCP_PARAMS_SVH
`define SRCP_PARAMS_SVH
`define SRCP_ADDR_W       5
`define SRCP_NREG         32
`define SRCP_CFG_ADDR     5'h00
`define SRCP_BIT_BIDIR    7
`define SRCP_BIT_LSB      6
`define SRCP_BIT_SRST     5
`define SRCP_REG_RST      8'h00
`define SRCP_INS_RW       7
`define SRCP_INS_LEN_HI   6
`define SRCP_INS_LEN_LO   5
`define SRCP_CLK_PS       4000
`define SRCP_SCLK_MAX_KHZ 15000
// half serial period in clk cycles, rounded up so sclk never beats the limit
`define SRCP_SCLK_HALF    (((1000000000 / `SRCP_SCLK_MAX_KHZ) + 2 * `SRCP_CLK_PS - 1) / (2 * `SRCP_CLK_PS))
`endif

// >>> rtl/srcp_pkg.sv
// types of the serial register control port
`include "srcp_params.svh"
package srcp_pkg;
  typedef enum logic [1:0] {ST_INSTR, ST_DATA, ST_DONE} srcp_dev_st_t;
  typedef enum logic [1:0] {HS_IDLE, HS_RUN, HS_TAIL} srcp_host_st_t;

  typedef struct packed {
    srcp_dev_st_t                        st;
    logic                                sclk_q;
    logic [2:0]                          bitc;
    logic [7:0]                          sh;
    logic [7:0]                          tx;
    logic                                rw;
    logic [1:0]                          left;
    logic [`SRCP_ADDR_W-1:0]             addr;
    logic                                dout;
    logic                                drv;
    logic                                wr;
    logic                                srst;
    logic [`SRCP_ADDR_W-1:0]             waddr;
    logic [7:0]                          wdata;
    logic [`SRCP_NREG-1:0][7:0]          regs;
  } srcp_dev_t;

  typedef struct packed {
    srcp_host_st_t st;
    logic          cs_n;
    logic          sclk;
    logic          dout;
    logic          oe;
    logic [3:0]    div;
    logic [5:0]    bitn;
    logic [5:0]    last;
    logic          rw;
    logic          lsb;
    logic [4:0][7:0] frame;
    logic [31:0]   rx;
    logic          done;
    logic [31:0]   rdata;
  } srcp_host_t;
endpackage

// >>> rtl/srcp_if.sv
// link between serial master and register port
`timescale 1ns/10ps
interface srcp_if;
  logic sclk;
  logic cs_n;
  logic sdio_h;
  logic sdio_h_oe;
  logic sdio_d;
  logic sdio_d_oe;
  logic serial_output_pin_d;
  logic serial_output_pin_oe;
  logic sdio;
  logic serial_output_pin;

  // wire levels, idle lines float high through pull-ups
  assign sdio = sdio_h_oe ? sdio_h : (sdio_d_oe ? sdio_d : 1'b1);
  assign serial_output_pin = serial_output_pin_oe ? serial_output_pin_d : 1'b1;

  modport host_mp (output sclk, cs_n, sdio_h, sdio_h_oe,
                   input  sdio, serial_output_pin);
  modport dev_mp  (input  sclk, cs_n, sdio,
                   output sdio_d, sdio_d_oe, serial_output_pin_d, serial_output_pin_oe);
endinterface

// >>> rtl/srcp_sync.sv
// two flip-flop synchroniser for a bundle of pins
`timescale 1ns/10ps
module srcp_sync #(
  parameter int unsigned   W       = 1,
  parameter logic [W-1:0]  RST_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } srcp_sync_t;

  srcp_sync_t sync_reg;
  srcp_sync_t sync_next;

  always_comb
  begin
    sync_next.s1 = d_i;
    sync_next.s2 = sync_reg.s1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sync_reg <= '{s1: RST_VAL, s2: RST_VAL};
    else
      sync_reg <= sync_next;
  end

  assign q_o = sync_reg.s2;
endmodule

// >>> rtl/srcp_device.sv
// device end: serial register port with 32 byte registers
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`include "srcp_params.svh"
module srcp_device (
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  srcp_if.dev_mp                       link,
  output logic                         reg_wr_o,
  output logic [`SRCP_ADDR_W-1:0]      reg_addr_o,
  output logic [7:0]                   reg_data_o,
  output logic                         soft_rst_o,
  output logic                         bidir_o,
  output logic                         lsb_first_o
);
  import srcp_pkg::*;

  // power-up defaults, pins undriven
  localparam srcp_pkg::srcp_dev_t DEV_RST = '{
    st:      ST_INSTR,
    sclk_q:  1'b0,
    bitc:    3'h0,
    sh:      8'h00,
    tx:      8'h00,
    rw:      1'b0,
    left:    2'h0,
    addr:    5'h00,
    dout:    1'b0,
    drv:     1'b0,
    wr:      1'b0,
    srst:    1'b0,
    waddr:   5'h00,
    wdata:   8'h00,
    regs:    {`SRCP_NREG{`SRCP_REG_RST}}
  };

  srcp_dev_t     dev_reg;
  srcp_dev_t     dev_next;
  logic [2:0]    pins_s;
  logic          sclk_s;
  logic          cs_n_s;
  logic          sdio_s;
  logic          bidir;
  logic          lsb;
  logic          rise;
  logic          fall;
  logic [7:0]    shifted;
  logic [7:0]    rbyte;
  logic          byte_end;
  logic          cfg_wr;
  logic          step_up;

  // pins from the host domain, cs idles high
  srcp_sync #(.W(3), .RST_VAL(3'b010)) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({link.sclk, link.cs_n, link.sdio}),
    .q_o     (pins_s)
  );

  assign sclk_s = pins_s[2];
  assign cs_n_s = pins_s[1];
  assign sdio_s = pins_s[0];

  always_comb
  begin
    dev_next      = dev_reg;
    dev_next.wr   = 1'b0;
    dev_next.srst = 1'b0;
    dev_next.sclk_q = sclk_s;
    bidir   = dev_reg.regs[`SRCP_CFG_ADDR][`SRCP_BIT_BIDIR];
    lsb     = dev_reg.regs[`SRCP_CFG_ADDR][`SRCP_BIT_LSB];
    rise    = sclk_s & ~dev_reg.sclk_q;
    fall    = ~sclk_s & dev_reg.sclk_q;
    // lsb first shifts in from the top, msb first from the bottom
    shifted = lsb ? {sdio_s, dev_reg.sh[7:1]} : {dev_reg.sh[6:0], sdio_s};
    step_up  = lsb;
    byte_end = (dev_reg.bitc == 3'h7);
    cfg_wr   = (dev_reg.addr == `SRCP_CFG_ADDR);
    // a read byte is fetched once, at its first bit
    if (dev_reg.bitc == 3'h0)
      rbyte = dev_reg.regs[dev_reg.addr];
    else
      rbyte = dev_reg.tx;

    if (cs_n_s)
    begin
      // deselected: drop any partial cycle, float the pins
      dev_next.st   = ST_INSTR;
      dev_next.bitc = 3'd0;
      dev_next.left = 2'h0;
      dev_next.rw   = 1'b0;
      dev_next.sh   = 8'h00;
      dev_next.tx   = 8'h00;
      dev_next.dout = 1'b0;
      dev_next.drv  = 1'b0;
    end
    else if (rise)
    begin
      // data sampled on the rising serial edge
      case (dev_reg.st)
        ST_INSTR:
        begin
          dev_next.sh   = shifted;
          dev_next.bitc = dev_reg.bitc + 3'd1;
          if (byte_end)
          begin
            dev_next.st   = ST_DATA;
            dev_next.rw   = shifted[`SRCP_INS_RW];
            dev_next.left = shifted[`SRCP_INS_LEN_HI:`SRCP_INS_LEN_LO];
            dev_next.addr = shifted[`SRCP_ADDR_W-1:0];
          end
        end
        ST_DATA:
        begin
          dev_next.sh   = shifted;
          dev_next.bitc = dev_reg.bitc + 3'd1;
          if (byte_end)
          begin
            if (!dev_reg.rw)
            begin
              // commit each byte as soon as its last bit is in
              dev_next.regs[dev_reg.addr] = shifted;
              dev_next.wr    = 1'b1;
              dev_next.waddr = dev_reg.addr;
              dev_next.wdata = shifted;
              if (cfg_wr && shifted[`SRCP_BIT_SRST])
              begin
                // register 0 keeps what was just written
                for (int i = 1; i < `SRCP_NREG; i++)
                begin
                  dev_next.regs[i] = `SRCP_REG_RST;
                end
                dev_next.srst = 1'b1;
              end
            end
            // step with the bit order now in force, wrap in 5 bits
            step_up = dev_next.regs[`SRCP_CFG_ADDR][`SRCP_BIT_LSB];
            if (step_up)
              dev_next.addr = dev_reg.addr + 5'd1;
            else
              dev_next.addr = dev_reg.addr - 5'd1;
            if (dev_reg.left == 2'd0)
              dev_next.st = ST_DONE;
            else
              dev_next.left = dev_reg.left - 2'd1;
          end
        end
        ST_DONE:
        begin
          // bits past the last byte are ignored
          dev_next.st = ST_DONE;
        end
        default:
        begin
          dev_next.st = ST_INSTR;
        end
      endcase
    end
    else if (fall && dev_reg.st == ST_DATA && dev_reg.rw)
    begin
      // read data launched on the falling serial edge
      dev_next.tx   = rbyte;
      dev_next.dout = lsb ? rbyte[dev_reg.bitc] : rbyte[~dev_reg.bitc];
      dev_next.drv  = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      dev_reg <= DEV_RST;
    else
      dev_reg <= dev_next;
  end

  // read data only on the pin that the mode selects
  assign link.sdio_d               = dev_reg.dout;
  assign link.sdio_d_oe            = dev_reg.drv & bidir;
  assign link.serial_output_pin_d  = dev_reg.dout;
  assign link.serial_output_pin_oe = dev_reg.drv & ~bidir;

  // user side copy of each committed byte
  assign reg_wr_o    = dev_reg.wr;
  assign reg_addr_o  = dev_reg.waddr;
  assign reg_data_o  = dev_reg.wdata;
  assign soft_rst_o  = dev_reg.srst;
  assign bidir_o     = bidir;
  assign lsb_first_o = lsb;
endmodule

// >>> rtl/srcp_host.sv
// host end: serial master issuing one read or write cycle per command
`timescale 1ns/10ps
`include "srcp_params.svh"
module srcp_host (
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  srcp_if.host_mp                      link,
  input  wire logic                    cmd_valid_i,
  output logic                         cmd_ready_o,
  input  wire logic                    cmd_rw_i,
  input  wire logic [1:0]              cmd_len_i,
  input  wire logic [`SRCP_ADDR_W-1:0] cmd_addr_i,
  input  wire logic [31:0]             cmd_wdata_i,
  input  wire logic                    lsb_first_i,
  input  wire logic                    bidir_i,
  output logic                         done_o,
  output logic [31:0]                  rdata_o
);
  import srcp_pkg::*;

  localparam logic [3:0] HALF = 4'(`SRCP_SCLK_HALF);

  localparam srcp_pkg::srcp_host_t HOST_RST = '{
    st:      HS_IDLE,
    cs_n:    1'b1,
    default: '0
  };

  srcp_host_t   host_reg;
  srcp_host_t   host_next;
  logic [1:0]   pins_s;
  logic         rd_in;
  logic         tick;
  logic [5:0]   nb;
  logic [7:0]   nbyte;
  logic [2:0]   rbyte;
  logic [2:0]   rbit;

  srcp_sync #(.W(2), .RST_VAL(2'b11)) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({link.sdio, link.serial_output_pin}),
    .q_o     (pins_s)
  );

  assign rd_in = bidir_i ? pins_s[1] : pins_s[0];

  always_comb
  begin
    host_next      = host_reg;
    host_next.done = 1'b0;
    tick  = (host_reg.div == HALF - 4'd1);
    nb    = host_reg.bitn + 6'd1;
    nbyte = host_reg.frame[nb[5:3]];
    rbyte = host_reg.bitn[5:3] - 3'd1;
    rbit  = host_reg.lsb ? host_reg.bitn[2:0] : ~host_reg.bitn[2:0];
    host_next.div = tick ? 4'd0 : host_reg.div + 4'd1;
    case (host_reg.st)
      HS_IDLE:
      begin
        host_next.div = 4'd0;
        if (cmd_valid_i)
        begin
          host_next.st    = HS_RUN;
          host_next.cs_n  = 1'b0;
          host_next.rw    = cmd_rw_i;
          host_next.lsb   = lsb_first_i;
          host_next.bitn  = 6'd0;
          // last bit index is 8 * (bytes + 1) - 1, kept wide enough for four bytes
          host_next.last  = {3'(cmd_len_i) + 3'h1, 3'b111};
          host_next.frame = {cmd_wdata_i, cmd_rw_i, cmd_len_i, cmd_addr_i};
          // first bit set up before the first rising edge
          host_next.dout  = lsb_first_i ? cmd_addr_i[0] : cmd_rw_i;
          host_next.oe    = 1'b1;
        end
      end
      HS_RUN:
      begin
        if (tick && !host_reg.sclk)
        begin
          host_next.sclk = 1'b1;
          if (host_reg.rw && host_reg.bitn[5:3] != 3'd0)
            host_next.rx[{rbyte[1:0], rbit}] = rd_in;
          if (host_reg.bitn == host_reg.last)
            host_next.st = HS_TAIL;
        end
        else if (tick)
        begin
          // next bit launched on the falling edge
          host_next.sclk = 1'b0;
          host_next.bitn = nb;
          host_next.dout = host_reg.lsb ? nbyte[nb[2:0]] : nbyte[~nb[2:0]];
          host_next.oe   = ~(host_reg.rw && nb[5:3] != 3'd0);
        end
      end
      HS_TAIL:
      begin
        if (tick && host_reg.sclk)
          host_next.sclk = 1'b0;
        else if (tick)
        begin
          host_next.st    = HS_IDLE;
          host_next.cs_n  = 1'b1;
          host_next.oe    = 1'b0;
          host_next.done  = 1'b1;
          host_next.rdata = host_reg.rx;
        end
      end
      default:
      begin
        host_next = HOST_RST;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      host_reg <= HOST_RST;
    else
      host_reg <= host_next;
  end

  assign link.sclk      = host_reg.sclk;
  assign link.cs_n      = host_reg.cs_n;
  assign link.sdio_h    = host_reg.dout;
  assign link.sdio_h_oe = host_reg.oe;
  assign cmd_ready_o    = (host_reg.st == HS_IDLE);
  assign done_o         = host_reg.done;
  assign rdata_o        = host_reg.rdata;
endmodule

// >>> bench/srcp_monitor.sv
// concurrent checks on the serial link between host and device
`timescale 1ns/10ps
module srcp_monitor (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic sdio_h,
  input  wire logic sdio_h_oe,
  input  wire logic sdio_d,
  input  wire logic sdio_d_oe,
  input  wire logic serial_output_pin_d,
  input  wire logic serial_output_pin_oe
);
  logic [5:0] rise_cnt;
  logic       sclk_q;

  // serial clock rises within the current frame
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rise_cnt <= 6'h00;
      sclk_q   <= 1'b0;
    end
    else
    begin
      sclk_q   <= sclk;
      rise_cnt <= cs_n ? 6'h00 : rise_cnt + {5'h00, sclk & ~sclk_q};
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_frame_rise_count: assert property ($rose(cs_n) |-> rise_cnt inside {6'h10, 6'h18, 6'h20, 6'h28})
    else $error("frame ended after a partial byte");
  a_instr_no_drive: assert property (!cs_n && rise_cnt inside {[1:7]} |-> !sdio_d_oe && !serial_output_pin_oe)
    else $error("device drove a pin during the instruction byte");
  a_host_data_hold: assert property (sclk |-> $stable(sdio_h))
    else $error("host data moved while serial clock high");
  a_dev_launch_fall: assert property ((sdio_d_oe && $changed(sdio_d)) || (serial_output_pin_oe && $changed(serial_output_pin_d)) |-> !sclk)
    else $error("device data moved while serial clock high");
  a_sclk_high_time: assert property ($rose(sclk) |=> sclk [*8])
    else $error("serial clock high phase too short");
  a_cs_idle_float: assert property (cs_n [*5] |-> !sdio_d_oe && !serial_output_pin_oe)
    else $error("device pin driven with chip select high");
  a_cs_spans_clk: assert property (sclk |-> !cs_n)
    else $error("serial clock high outside a frame");
  a_no_contention: assert property (!(sdio_h_oe && sdio_d_oe))
    else $error("host and device both drive the data pin");
  a_one_read_pin: assert property (!(sdio_d_oe && serial_output_pin_oe))
    else $error("device drives both data pins");
endmodule

// >>> bench/test_serial_register_control_port.sv
// self-checking bench: host and device joined over the serial link
`timescale 1ns/10ps
module test_serial_register_control_port;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        cmd_rw = 1'b0;
  logic [1:0]  cmd_len = 2'h0;
  logic [4:0]  cmd_addr = 5'h00;
  logic [31:0] cmd_wdata = 32'h0;
  logic        lsb = 1'b0;
  logic        bidir = 1'b0;
  logic        cmd_ready, done, reg_wr, soft_rst, bidir_o, lsb_o;
  logic [4:0]  reg_addr;
  logic [7:0]  reg_data;
  logic [31:0] rdata;
  logic        srst_seen = 1'b0;
  logic [13:0] wq[$];
  int          err_total = 0;
  int          checked = 0;

  srcp_if u_srcp_if ();
  srcp_host u_srcp_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(u_srcp_if),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_rw_i(cmd_rw), .cmd_len_i(cmd_len),
    .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata), .lsb_first_i(lsb), .bidir_i(bidir),
    .done_o(done), .rdata_o(rdata));
  srcp_device u_srcp_device (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(u_srcp_if),
    .reg_wr_o(reg_wr), .reg_addr_o(reg_addr), .reg_data_o(reg_data), .soft_rst_o(soft_rst),
    .bidir_o(bidir_o), .lsb_first_o(lsb_o));
  srcp_monitor u_srcp_monitor (.clk_i(clk_i), .rst_n_i(rst_n_i), .sclk(u_srcp_if.sclk),
    .cs_n(u_srcp_if.cs_n), .sdio_h(u_srcp_if.sdio_h), .sdio_h_oe(u_srcp_if.sdio_h_oe),
    .sdio_d(u_srcp_if.sdio_d), .sdio_d_oe(u_srcp_if.sdio_d_oe),
    .serial_output_pin_d(u_srcp_if.serial_output_pin_d),
    .serial_output_pin_oe(u_srcp_if.serial_output_pin_oe));

  always #2 clk_i = ~clk_i;

  // log of committed bytes with chip select level at commit
  // sampled mid-cycle, clear of the edge that updates them
  always @(negedge clk_i)
  begin
    if (reg_wr === 1'b1)
      wq.push_back({u_srcp_if.cs_n, reg_addr, reg_data});
    if (soft_rst === 1'b1)
      srst_seen <= 1'b1;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (err_total == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one command through the host, bounded wait for its end
  task automatic xfer(input logic rw, input logic [1:0] len, input logic [4:0] a,
                      input logic [31:0] wd);
    int n;
    n = 0;
    repeat (4) @(posedge clk_i);
    cmd_valid <= 1'b1;
    cmd_rw    <= rw;
    cmd_len   <= len;
    cmd_addr  <= a;
    cmd_wdata <= wd;
    @(posedge clk_i);
    cmd_valid <= 1'b0;
    #1;
    chk("busy", 32'(cmd_ready), 32'h0);
    while (done !== 1'b1 && n < 3000)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk("done", 32'(done), 32'h1);
    chk("ready", 32'(cmd_ready), 32'h1);
  endtask

  task automatic wexp(input logic [4:0] a, input logic [7:0] d);
    chk("commit", 32'(wq.size() > 0 ? wq.pop_front() : 14'h3fff), {18'h0, 1'b0, a, d});
  endtask

  task automatic t_reset();
    chk("bidir", 32'(bidir_o), 32'h0);
    chk("lsb", 32'(lsb_o), 32'h0);
    chk("sdo idle", 32'(u_srcp_if.serial_output_pin), 32'h1);
  endtask

  task automatic t_msb_wrap();
    xfer(1'b0, 2'h3, 5'h01, 32'h5ac311a5);
    wexp(5'h01, 8'ha5);
    wexp(5'h00, 8'h11);
    wexp(5'h1f, 8'hc3);
    wexp(5'h1e, 8'h5a);
  endtask

  task automatic t_read_lens();
    logic [31:0] m;
    for (int l = 0; l < 4; l++)
    begin
      m = 32'hffffffff >> (8 * (3 - l));
      xfer(1'b1, 2'(l), 5'h01, 32'h0);
      chk("rdata", rdata & m, 32'h5ac311a5 & m);
      chk("read commits", 32'(wq.size()), 32'h0);
    end
  endtask

  task automatic t_lsb_bidir();
    xfer(1'b0, 2'h0, 5'h00, 32'h000000c0);
    chk("bidir", 32'(bidir_o), 32'h1);
    chk("lsb", 32'(lsb_o), 32'h1);
    wexp(5'h00, 8'hc0);
    @(posedge clk_i);
    lsb   <= 1'b1;
    bidir <= 1'b1;
    xfer(1'b0, 2'h3, 5'h1e, 32'h77c06655);
    wexp(5'h1e, 8'h55);
    wexp(5'h1f, 8'h66);
    wexp(5'h00, 8'hc0);
    wexp(5'h01, 8'h77);
    xfer(1'b1, 2'h3, 5'h1e, 32'h0);
    chk("rdata", rdata, 32'h77c06655);
  endtask

  task automatic t_soft_reset();
    xfer(1'b0, 2'h0, 5'h00, 32'h000000e0);
    chk("srst", 32'(srst_seen), 32'h1);
    wexp(5'h00, 8'he0);
    xfer(1'b1, 2'h1, 5'h00, 32'h0);
    chk("rdata", 32'(rdata[15:0]), 32'h000000e0);
  endtask

  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_msb_wrap();
    t_read_lens();
    t_lsb_bidir();
    t_soft_reset();
    end_sim();
  end

  initial
  begin
    #100000;
    err_total++;
    end_sim();
  end
endmodule
